// *** bench/aocc_chk_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module aocc_chk
  import aocc_pkg::*;
(
  input  wire logic        clk_i,           // Core clock
  input  wire logic        rst_i,           // Synchronous reset
  input  wire logic        chk_valid_i,     // Request strobe
  input  wire aocc_req_t   chk_req_i,       // Request contents
  input  wire logic        exc_pulse_o,     // Exception pulse
  input  wire aocc_cause_t exc_cause_o,     // Cause code
  input  wire logic [15:0] exc_vector_o,    // Vector offset
  input  wire logic        commit_ok_o,     // Commit permission
  input  wire aocc_class_t insn_class_o,    // Opcode class
  input  wire logic        misaligned_o,    // Off boundary
  input  wire logic        split_access_o,  // Extra access
  input  wire logic [31:0] fetch_address_o  // Fetch address out
);
  // Checks assume the enable bit stays set, as the bench keeps it
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [5:0]  prim;   // Primary opcode field
  logic [29:0] fa_hi;  // Word part of fetch address
  assign prim  = chk_req_i.insn[31:26];
  assign fa_hi = chk_req_i.fetch_address[31:2];
  //////////////////////////////////////////////////////////////////////////////
  // Request shapes
  sequence s_req(k);
    chk_valid_i && chk_req_i.kind == k;
  endsequence
  sequence s_zero;
    chk_valid_i && chk_req_i.insn == 32'h0;
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  property p_zero;
    s_zero |=> insn_class_o == AOCC_CL_ILLEGAL && exc_cause_o == AOCC_C_ILLEGAL;
  endproperty
  property p_resv;
    chk_valid_i && prim == 6'h0 && chk_req_i.insn != 32'h0 |=> insn_class_o == AOCC_CL_RESERVED && exc_pulse_o;
  endproperty
  property p_prim;
    chk_valid_i && prim inside {6'd1, 6'd5, 6'd6, 6'd56, 6'd57, 6'd60, 6'd61} |=> insn_class_o == AOCC_CL_ILLEGAL;
  endproperty
  property p_vec;
    exc_pulse_o && exc_cause_o == AOCC_C_ALIGN |-> exc_vector_o == 16'h0600;
  endproperty
  property p_pulse;
    exc_pulse_o |-> $past(chk_valid_i) && !commit_ok_o;
  endproperty
  property p_dcbz;
    s_req(AOCC_K_DCBZ) ##0 !chk_req_i.data_translation_enable && !chk_req_i.cacheable |=> exc_pulse_o;
  endproperty
  property p_resv_ea;
    s_req(AOCC_K_RESV) ##0 chk_req_i.effective_address[1:0] != 2'h0 |=> exc_pulse_o;
  endproperty
  property p_ldst;
    s_req(AOCC_K_LDST) |=> insn_class_o != AOCC_CL_DEFINED || (!exc_pulse_o && commit_ok_o);
  endproperty
  property p_cache;
    s_req(AOCC_K_CACHE) |=> !misaligned_o && exc_cause_o != AOCC_C_ALIGN;
  endproperty
  property p_half;
    s_req(AOCC_K_LDST) ##0 chk_req_i.size == AOCC_SZ_HALF && chk_req_i.effective_address[0]
      |=> misaligned_o && split_access_o;
  endproperty
  property p_fetch;
    chk_valid_i |=> fetch_address_o[1:0] == 2'h0 && fetch_address_o[31:2] == $past(fa_hi);
  endproperty
  a_zero: assert property (p_zero) else $error("zero word not illegal");
  a_resv: assert property (p_resv) else $error("reserved word not trapped");
  a_prim: assert property (p_prim) else $error("unused primary not illegal");
  a_vec: assert property (p_vec) else $error("alignment vector wrong");
  a_pulse: assert property (p_pulse) else $error("stray exception pulse");
  a_dcbz: assert property (p_dcbz) else $error("zero block not trapped");
  a_resv_ea: assert property (p_resv_ea) else $error("reservation op not trapped");
  a_ldst: assert property (p_ldst) else $error("plain access excepted");
  a_cache: assert property (p_cache) else $error("cache op misaligned");
  a_half: assert property (p_half) else $error("odd halfword not split");
  a_fetch: assert property (p_fetch) else $error("fetch address not word");
endmodule : aocc_chk
bind aocc_top aocc_chk u_chk (.clk_i, .rst_i, .chk_valid_i, .chk_req_i, .exc_pulse_o, .exc_cause_o,
  .exc_vector_o, .commit_ok_o, .insn_class_o, .misaligned_o, .split_access_o, .fetch_address_o);
`default_nettype wire

// *** bench/aocc_pipe_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module aocc_pipe_model
  import aocc_pkg::*;
(
  input  wire logic clk_i,        // Core clock
  output logic      chk_valid_o,  // Request strobe
  output aocc_req_t chk_req_o     // Request contents
);
  initial begin
    chk_valid_o = 1'b0;
    chk_req_o   = '0;
  end
  // One cycle of request, then the bus shows garbage, never the old value
  task automatic issue(input aocc_req_t r);
    chk_valid_o <= 1'b1;
    chk_req_o   <= r;
    @(posedge clk_i);
    chk_valid_o <= 1'b0;
    chk_req_o   <= ~r;
  endtask : issue
endmodule : aocc_pipe_model
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import aocc_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, irq, valid, pulse, commit, mis, split, rv;
  logic [3:0]  sel = 4'hf, wsel = 4'hf;  // Byte lanes on the bus, and the lanes the next access uses
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, rd, fa;
  logic [15:0] vec;
  aocc_req_t   req;
  aocc_cause_t cause;
  aocc_class_t cls;
  int          n_fail = 0, num_checks = 0, cycles = 0;
  logic [7:0]  offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
  logic [5:0]  prims [7] = '{6'd1, 6'd5, 6'd6, 6'd56, 6'd57, 6'd60, 6'd61};
  localparam logic [31:0] ADDI = 32'h38000000;  // Plain defined word
  aocc_top u_dut (.clk_i, .rst_i, .chk_valid_i(valid), .chk_req_i(req), .exc_pulse_o(pulse),
    .exc_cause_o(cause), .exc_vector_o(vec), .commit_ok_o(commit), .rsp_valid_o(rv), .insn_class_o(cls),
    .misaligned_o(mis), .split_access_o(split), .fetch_address_o(fa), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_o(irq));
  aocc_pipe_model u_pipe (.clk_i, .chk_valid_o(valid), .chk_req_o(req));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Watchdog: a hung bus wait ends the run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= wsel;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check("register", rd, exp);
  endtask : rdchk
  function automatic aocc_req_t mk(input logic [31:0] i, input logic [31:0] ea, input aocc_kind_t k,
                                   input aocc_size_t s, input logic [2:0] dcw);
    mk = '{insn:i, effective_address:ea, fetch_address:32'h1003, size:s, kind:k,
           data_translation_enable:dcw[2], cacheable:dcw[1], write_through:dcw[0]};
  endfunction : mk
  // Opcode class and trap of one word; verdict shows one cycle later
  task automatic dec(input logic [31:0] i, input aocc_class_t c);
    u_pipe.issue(mk(i, 32'h0, AOCC_K_NONE, AOCC_SZ_WORD, 3'b110));
    #1;
    check("class", cls, c);
    check("cause", cause, c == AOCC_CL_DEFINED ? AOCC_C_NONE : AOCC_C_ILLEGAL);
    check("fetch", fa, 32'h1000);
    check("rsp_valid", rv, 1'b1);
  endtask : dec
  // Alignment verdict, expected value worked out from size and kind
  task automatic align(input aocc_kind_t k, input aocc_size_t s, input logic [31:0] ea, input logic [2:0] dcw);
    logic m, e, x;
    // Block ops drop the low address bits, so they are never misaligned
    m = k != AOCC_K_CACHE && k != AOCC_K_DCBZ &&
        ((s == AOCC_SZ_HALF && ea[0]) || (s == AOCC_SZ_WORD && ea[1:0] != 2'h0)
        || (s == AOCC_SZ_DOUBLE && ea[2:0] != 3'h0));
    // Plain access needs a second cycle when misaligned or running past the word
    x = k == AOCC_K_LDST && (m || int'(ea[1:0]) + (1 << s) > 4);
    e = (k == AOCC_K_RESV && ea[1:0] != 2'h0) || (k == AOCC_K_DCBZ && !dcw[2] && (!dcw[1] || dcw[0]));
    u_pipe.issue(mk(ADDI, ea, k, s, dcw));
    #1;
    check("misaligned", mis, m);
    check("split", split, x);
    check("pulse", pulse, e);
    check("vector", vec, e ? 16'h0600 : 16'h0);
    check("commit", commit, !e);
  endtask : align
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, wdat} = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (offs[i]) rdchk(offs[i], offs[i] == 8'h00 ? 32'h1 : 32'h0);
    wb(1'b1, 8'h00, 32'h3);
    rdchk(8'h00, 32'h3);
    dec(32'h0, AOCC_CL_ILLEGAL);
    check("irq", irq, 1'b0);
    wb(1'b1, 8'h08, 32'hf);
    @(posedge clk_i);
    #1;
    check("irq", irq, 1'b1);
    check("rsp_valid", rv, 1'b0);
    wsel = 4'he;
    wb(1'b1, 8'h08, 32'h0);
    wsel = 4'hf;
    rdchk(8'h08, 32'hf);
    dec(32'h1, AOCC_CL_RESERVED);
    foreach (prims[i]) dec({prims[i], 26'h0}, AOCC_CL_ILLEGAL);
    dec(ADDI, AOCC_CL_DEFINED);
    dec(32'h7ce72214, AOCC_CL_DEFINED);
    dec(32'h4c00012c, AOCC_CL_DEFINED);
    dec(32'h7c0007fe, AOCC_CL_ILLEGAL);
    dec(32'h4c000002, AOCC_CL_ILLEGAL);
    dec(32'hec00002a, AOCC_CL_ILLEGAL);
    dec(32'hfc00002a, AOCC_CL_ILLEGAL);
    dec(32'h7c00026c, AOCC_CL_ILLEGAL);
    dec(32'h7c000264, AOCC_CL_ILLEGAL);
    dec(32'h84000000, AOCC_CL_ILLEGAL);
    align(AOCC_K_LDST, AOCC_SZ_HALF, 32'h1, 3'b110);
    align(AOCC_K_LDST, AOCC_SZ_HALF, 32'h2, 3'b110);
    align(AOCC_K_LDST, AOCC_SZ_WORD, 32'h2, 3'b110);
    align(AOCC_K_LDST, AOCC_SZ_WORD, 32'h4, 3'b110);
    align(AOCC_K_LDST, AOCC_SZ_DOUBLE, 32'h4, 3'b110);
    align(AOCC_K_LDST, AOCC_SZ_BYTE, 32'h3, 3'b110);
    align(AOCC_K_LDST, AOCC_SZ_DOUBLE, 32'h8, 3'b110);
    align(AOCC_K_RESV, AOCC_SZ_WORD, 32'h2, 3'b110);
    align(AOCC_K_RESV, AOCC_SZ_WORD, 32'h4, 3'b110);
    align(AOCC_K_DCBZ, AOCC_SZ_WORD, 32'h0, 3'b000);
    align(AOCC_K_DCBZ, AOCC_SZ_WORD, 32'h0, 3'b011);
    align(AOCC_K_DCBZ, AOCC_SZ_WORD, 32'h0, 3'b010);
    align(AOCC_K_DCBZ, AOCC_SZ_WORD, 32'h0, 3'b100);
    align(AOCC_K_CACHE, AOCC_SZ_WORD, 32'hf, 3'b000);
    align(AOCC_K_DCBZ, AOCC_SZ_WORD, 32'h3, 3'b100);
    u_pipe.issue(mk(32'h04000000, 32'h6, AOCC_K_RESV, AOCC_SZ_WORD, 3'b110));
    #1;
    check("cause", cause, AOCC_C_ILLEGAL);
    check("vector", vec, 16'h0);
    rdchk(8'h04, 32'hf);
    @(posedge clk_i);
    #1;
    check("irq", irq, 1'b0);
    rdchk(8'h04, 32'h0);
    wb(1'b1, 8'h0c, 32'hffffffff);
    rdchk(8'h0c, 32'h6);
    rdchk(8'h10, 32'h04000000);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire

// *** src/aocc_align.sv ***
`timescale 1ns/1ps
`default_nettype none
module aocc_align
  import aocc_pkg::*;
(
  input  wire  aocc_req_t   req_i,  // Request under check
  output aocc_align_t       res_o   // Alignment verdict
);

  logic [3:0] low;      // Low address bits seen by the check
  logic [3:0] need;     // Bits that must be clear for this size
  logic [3:0] nbytes;   // Operand length
  logic [4:0] reach;    // End offset within the word

  // Pure alignment logic; the endian attribute is not even an input
  always_comb begin
    low   = req_i.effective_address[3:0];
    unique case (req_i.size)  // [RULE_01]
      AOCC_SZ_BYTE:   begin need = 4'h0; nbytes = 4'h1; end
      AOCC_SZ_HALF:   begin need = 4'h1; nbytes = 4'h2; end
      AOCC_SZ_WORD:   begin need = 4'h3; nbytes = 4'h4; end
      AOCC_SZ_DOUBLE: begin need = 4'h7; nbytes = 4'h8; end
    endcase
    // Cache ops look at a block, so the low bits are dropped
    if (req_i.kind == AOCC_K_CACHE || req_i.kind == AOCC_K_DCBZ) begin
      low = 4'h0;  // [RULE_07]
    end
    reach = {3'h0, low[1:0]} + {1'h0, nbytes};
    res_o.misaligned   = |(low & need);  // [RULE_03]
    res_o.crosses_word = (req_i.kind == AOCC_K_LDST) && (reach > 5'h04);
    unique case (req_i.kind)
      AOCC_K_RESV:  res_o.align_exc = |req_i.effective_address[1:0];  // [RULE_05]
      AOCC_K_DCBZ:  res_o.align_exc = !req_i.data_translation_enable &&
                                      (!req_i.cacheable || req_i.write_through);  // [RULE_06]
      default:      res_o.align_exc = 1'b0;  // Loads/stores split silently [RULE_04]
    endcase
  end

endmodule : aocc_align
`default_nettype wire

// *** src/aocc_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module aocc_decode
  import aocc_pkg::*;
(
  input  wire  logic [31:0] insn_i,      // Big-endian instruction word
  input  wire  logic        inv_trap_i,  // Trap invalid forms
  output aocc_dec_t         res_o        // Class and trap verdict
);

  logic [5:0] prim;   // Primary opcode
  logic [9:0] xo;     // Extended opcode
  logic [4:0] rt;     // Target field
  logic [4:0] ra;     // Base field
  logic       inv;    // Invalid form seen

  // Only the integer subset is defined; float, external control and
  // TLB invalidate are absent from the tables so software emulates them
  always_comb begin
    prim = insn_i[31:26];
    xo   = insn_i[10:1];
    rt   = insn_i[25:21];
    ra   = insn_i[20:16];
    res_o.cls = AOCC_CL_ILLEGAL;  // Anything unlisted [RULE_10]
    if (insn_i == 32'h0000_0000) begin
      res_o.cls = AOCC_CL_ILLEGAL;  // [RULE_11]
    end else if (prim == 6'h00) begin
      res_o.cls = AOCC_CL_RESERVED;  // [RULE_11]
    end else if (prim == 6'h13) begin
      if (xo inside {10'h000, 10'h010, 10'h021, 10'h032, 10'h033, 10'h081, 10'h096,
                     10'h0c1, 10'h0e1, 10'h101, 10'h121, 10'h1a1, 10'h1c1, 10'h210}) begin
        res_o.cls = AOCC_CL_DEFINED;  // [RULE_09]
      end
    end else if (prim == 6'h1f) begin
      if (xo inside {10'h000, 10'h004, 10'h008, 10'h208, 10'h00a, 10'h20a, 10'h00b, 10'h013,
                     10'h014, 10'h017, 10'h018, 10'h01a, 10'h01c, 10'h020, 10'h028, 10'h228,
                     10'h036, 10'h037, 10'h03c, 10'h04b, 10'h053, 10'h056, 10'h057, 10'h068,
                     10'h268, 10'h077, 10'h07c, 10'h083, 10'h088, 10'h288, 10'h08a, 10'h28a,
                     10'h090, 10'h092, 10'h096, 10'h097, 10'h0a3, 10'h0b7, 10'h0c8, 10'h2c8,
                     10'h0ca, 10'h2ca, 10'h0d7, 10'h0e8, 10'h2e8, 10'h0ea, 10'h2ea, 10'h0eb,
                     10'h2eb, 10'h0f6, 10'h0f7, 10'h106, 10'h10a, 10'h30a, 10'h116, 10'h117,
                     10'h11c, 10'h137, 10'h13c, 10'h143, 10'h153, 10'h157, 10'h173, 10'h177,
                     10'h197, 10'h19c, 10'h1b7, 10'h1bc, 10'h1c3, 10'h1c6, 10'h1cb, 10'h3cb,
                     10'h1d3, 10'h1d6, 10'h1dc, 10'h1e6, 10'h1eb, 10'h3eb, 10'h200, 10'h215,
                     10'h216, 10'h218, 10'h236, 10'h255, 10'h256, 10'h295, 10'h296, 10'h2d5,
                     10'h2f6, 10'h316, 10'h318, 10'h338, 10'h356, 10'h392, 10'h396, 10'h39a,
                     10'h3b2, 10'h3ba, 10'h3c6, 10'h3d2, 10'h3d6, 10'h3e6, 10'h3f6}) begin
        res_o.cls = AOCC_CL_DEFINED;  // [RULE_09] [RULE_13]
      end
    end else if (prim inside {6'h03, 6'h04, 6'h07, 6'h08, 6'h0a, 6'h0b, 6'h0c, 6'h0d,
                              6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12, 6'h14, 6'h15, 6'h17,
                              [6'h18:6'h1d], [6'h20:6'h2f]}) begin
      res_o.cls = AOCC_CL_DEFINED;  // 1,5,6,56,57,60,61 and 59/63 fall through [RULE_08] [RULE_13]
    end
    // Update forms with base zero, or multiple-load overwriting its base
    inv = (prim inside {6'h21, 6'h23, 6'h25, 6'h27, 6'h29, 6'h2b, 6'h2d} && ra == 5'h00) ||
          (prim == 6'h2e && ra != 5'h00 && ra >= rt);
    if (res_o.cls == AOCC_CL_DEFINED && inv && inv_trap_i) begin
      res_o.cls = AOCC_CL_ILLEGAL;  // [RULE_14]
    end
    // No reserved opcode is implemented here, so every one traps
    res_o.trap = (res_o.cls != AOCC_CL_DEFINED);  // [RULE_12] [RULE_15]
  end

endmodule : aocc_decode
`default_nettype wire

// *** src/aocc_pkg.sv ***
// Functional notes
// RULE_01: Aligned when low address bits fit size
// RULE_02: Instruction fetch addresses forced to word boundary
// RULE_03: Endian attribute never affects alignment checks
// RULE_04: Ordinary misaligned loads/stores complete, no exception
// RULE_05: Reservation/dcread ops need word-aligned address
// RULE_06: Zero-block with translation off, uncacheable/write-through faults
// RULE_07: Cache ops drop low four bits, never misalign
// RULE_08: Primaries 1,5,6,56,57,60,61 are illegal
// RULE_09: Unused extended opcodes under 19/31/59/63 illegal
// RULE_10: Class from primary plus extended opcode
// RULE_11: All-zero word illegal; primary zero reserved
// RULE_12: Illegal instruction raises program exception
// RULE_13: Optional unimplemented instructions trap as illegal
// RULE_14: Some invalid forms trap as illegal
// RULE_15: Unimplemented reserved instruction traps as illegal
// RULE_16: Check before commit; one-cycle pulse with cause
// RULE_17: Illegal instruction outranks alignment exception
package aocc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte offsets on the bus
  localparam logic [7:0]  AOCC_CTRL_OFS      = 8'h00;  // Check controls
  localparam logic [7:0]  AOCC_STATUS_OFS    = 8'h04;  // Sticky events, read clears
  localparam logic [7:0]  AOCC_MASK_OFS      = 8'h08;  // Interrupt mask
  localparam logic [7:0]  AOCC_LAST_EA_OFS   = 8'h0c;  // Address of last exception
  localparam logic [7:0]  AOCC_LAST_INSN_OFS = 8'h10;  // Word of last exception

  // Field positions
  localparam int AOCC_CTRL_EN_BIT    = 0;              // Raise exceptions at all
  localparam int AOCC_CTRL_INVF_BIT  = 1;              // Trap invalid forms
  localparam int AOCC_EV_ALIGN_BIT   = 0;              // Alignment exception raised
  localparam int AOCC_EV_ILLEGAL_BIT = 1;              // Program exception raised
  localparam int AOCC_EV_SPLIT_BIT   = 2;              // Split access absorbed, misaligned or running past the word
  localparam int AOCC_EV_RESV_BIT    = 3;              // Reserved-class trap
  localparam int AOCC_EV_W           = 4;              // Event field width

  // Values after reset
  localparam logic [1:0]          AOCC_CTRL_RST = 2'h1;  // Checks on, forms lenient
  localparam logic [AOCC_EV_W-1:0] AOCC_MASK_RST = 4'h0; // All events masked

  // Vector offset reported with an alignment exception
  localparam logic [15:0] AOCC_ALIGN_VECTOR = 16'h0600;

  ////////////////////////////////////////////////////////////////////////////
  // Enumerations
  typedef enum logic [1:0] {AOCC_SZ_BYTE, AOCC_SZ_HALF, AOCC_SZ_WORD, AOCC_SZ_DOUBLE} aocc_size_t;
  typedef enum logic [2:0] {AOCC_K_NONE, AOCC_K_LDST, AOCC_K_RESV, AOCC_K_DCBZ, AOCC_K_CACHE} aocc_kind_t;
  typedef enum logic [1:0] {AOCC_CL_DEFINED, AOCC_CL_RESERVED, AOCC_CL_ILLEGAL} aocc_class_t;
  typedef enum logic [1:0] {AOCC_C_NONE, AOCC_C_ALIGN, AOCC_C_ILLEGAL} aocc_cause_t;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [31:0] insn;               // Fetched word, big-endian order
    logic [31:0] effective_address;  // Operand address
    logic [31:0] fetch_address;      // Address the word came from
    aocc_size_t  size;               // Operand size
    aocc_kind_t  kind;               // Memory operation kind
    logic        data_translation_enable;
    logic        cacheable;          // Target region cacheable
    logic        write_through;      // Target region write-through
  } aocc_req_t;

  typedef struct packed {
    logic misaligned;    // Not on natural boundary
    logic crosses_word;  // Needs a second access
    logic align_exc;     // Alignment exception due
  } aocc_align_t;

  typedef struct packed {
    aocc_class_t cls;    // Opcode class
    logic        trap;   // Program exception due
  } aocc_dec_t;

endpackage : aocc_pkg

// *** src/aocc_top.sv ***
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module aocc_top
  import aocc_pkg::*;
(
  input  wire  logic        clk_i,           // Core clock
  input  wire  logic        rst_i,           // Synchronous reset, high
  // Pipeline side
  input  wire  logic        chk_valid_i,     // Request present this cycle
  input  wire  aocc_req_t   chk_req_i,       // Request contents
  output logic              exc_pulse_o,     // One-cycle exception pulse
  output aocc_cause_t       exc_cause_o,     // Cause with the pulse
  output logic [15:0]       exc_vector_o,    // Vector offset with an alignment pulse
  output logic              commit_ok_o,     // Result may be committed
  output logic              rsp_valid_o,     // Verdict valid
  output aocc_class_t       insn_class_o,    // Opcode class
  output logic              misaligned_o,    // Operand off natural boundary
  output logic              split_access_o,  // Extra access cycle needed
  output logic [31:0]       fetch_address_o, // Word-aligned fetch address
  // Wishbone slave
  input  wire  logic        wb_cyc_i,        // Bus cycle
  input  wire  logic        wb_stb_i,        // Strobe
  input  wire  logic        wb_we_i,         // Write enable
  input  wire  logic [7:0]  wb_adr_i,        // Byte address
  input  wire  logic [3:0]  wb_sel_i,        // Byte lanes
  input  wire  logic [31:0] wb_dat_i,        // Write data
  output logic [31:0]       wb_dat_o,        // Read data
  output logic              wb_ack_o,        // Acknowledge
  output logic              irq_o            // Level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // Checkers
  aocc_align_t al;  // Alignment verdict
  aocc_dec_t   dc;  // Decode verdict
  logic [1:0]  ctrl;  // Control register
  logic [1:0]  next_ctrl;

  aocc_align u_align (
    .req_i (chk_req_i),
    .res_o (al)
  );

  aocc_decode u_decode (
    .insn_i     (chk_req_i.insn),
    .inv_trap_i (ctrl[AOCC_CTRL_INVF_BIT]),
    .res_o      (dc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Verdict stage: one cycle after the request, before any commit
  logic              next_exc_pulse;
  aocc_cause_t       next_exc_cause;
  logic [15:0]       next_exc_vector;
  logic              next_commit_ok;
  logic              next_rsp_valid;
  aocc_class_t       next_insn_class;
  logic              next_misaligned;
  logic              next_split;
  logic [31:0]       next_fetch_address;
  logic [AOCC_EV_W-1:0] ev;  // Events this cycle

  // Illegal is tested first: an alignment exception is never raised then
  always_comb begin
    next_exc_pulse     = 1'b0;
    next_exc_cause     = AOCC_C_NONE;
    next_exc_vector    = 16'h0000;
    next_rsp_valid     = chk_valid_i;
    next_insn_class    = dc.cls;
    next_misaligned    = chk_valid_i && al.misaligned;
    next_split         = chk_valid_i && (al.misaligned || al.crosses_word) &&
                         chk_req_i.kind == AOCC_K_LDST;  // [RULE_04]
    next_fetch_address = {chk_req_i.fetch_address[31:2], 2'h0};  // [RULE_02]
    ev                 = '0;
    if (chk_valid_i && ctrl[AOCC_CTRL_EN_BIT]) begin
      if (dc.trap) begin
        next_exc_pulse = 1'b1;  // [RULE_12] [RULE_17]
        next_exc_cause = AOCC_C_ILLEGAL;
        ev[AOCC_EV_ILLEGAL_BIT] = 1'b1;
        ev[AOCC_EV_RESV_BIT]    = (dc.cls == AOCC_CL_RESERVED);  // [RULE_15]
      end else if (al.align_exc) begin
        next_exc_pulse  = 1'b1;  // [RULE_05] [RULE_06]
        next_exc_cause  = AOCC_C_ALIGN;
        next_exc_vector = AOCC_ALIGN_VECTOR;  // [RULE_06]
        ev[AOCC_EV_ALIGN_BIT] = 1'b1;
      end
    end
    ev[AOCC_EV_SPLIT_BIT] = next_split;
    next_commit_ok = chk_valid_i && !next_exc_pulse;  // [RULE_16]
  end

  // Verdict registers; the pulse lasts exactly one cycle per request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exc_pulse_o     <= 1'b0;
      exc_cause_o     <= AOCC_C_NONE;
      exc_vector_o    <= 16'h0000;
      commit_ok_o     <= 1'b0;
      rsp_valid_o     <= 1'b0;
      insn_class_o    <= AOCC_CL_DEFINED;
      misaligned_o    <= 1'b0;
      split_access_o  <= 1'b0;
      fetch_address_o <= 32'h0000_0000;
    end else begin
      exc_pulse_o     <= next_exc_pulse;  // [RULE_16]
      exc_cause_o     <= next_exc_cause;
      exc_vector_o    <= next_exc_vector;
      commit_ok_o     <= next_commit_ok;
      rsp_valid_o     <= next_rsp_valid;
      insn_class_o    <= next_insn_class;
      misaligned_o    <= next_misaligned;
      split_access_o  <= next_split;
      fetch_address_o <= next_fetch_address;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [AOCC_EV_W-1:0] status;       // Sticky events
  logic [AOCC_EV_W-1:0] next_status;
  logic [AOCC_EV_W-1:0] mask;         // Interrupt mask
  logic [AOCC_EV_W-1:0] next_mask;
  logic [31:0]          last_ea;      // Address of last exception
  logic [31:0]          next_last_ea;
  logic [31:0]          last_insn;    // Word of last exception
  logic [31:0]          next_last_insn;
  logic [31:0]          next_dat;
  logic                 next_ack;
  logic                 next_irq;
  logic                 acc;          // Access completes this edge
  logic                 wr;           // Write with low lane enabled

  // Decode, side effects and read mux; ack comes one cycle after strobe
  always_comb begin
    next_ack       = wb_cyc_i && wb_stb_i && !wb_ack_o;
    acc            = next_ack;
    wr             = acc && wb_we_i && wb_sel_i[0];
    next_ctrl      = ctrl;
    next_mask      = mask;
    next_last_ea   = last_ea;
    next_last_insn = last_insn;
    next_dat       = 32'h0000_0000;
    next_status    = status | ev;
    // Read clears, but an event in the same cycle survives
    if (acc && !wb_we_i && wb_adr_i == AOCC_STATUS_OFS) begin
      next_status = ev;
    end
    if (next_exc_pulse) begin
      next_last_ea   = chk_req_i.effective_address;
      next_last_insn = chk_req_i.insn;
    end
    if (wr && wb_adr_i == AOCC_CTRL_OFS) begin
      next_ctrl = wb_dat_i[1:0];
    end
    if (wr && wb_adr_i == AOCC_MASK_OFS) begin
      next_mask = wb_dat_i[AOCC_EV_W-1:0];
    end
    if (acc && !wb_we_i) begin
      unique case (wb_adr_i)
        AOCC_CTRL_OFS:      next_dat = {30'h0, ctrl};
        AOCC_STATUS_OFS:    next_dat = {28'h0, status};
        AOCC_MASK_OFS:      next_dat = {28'h0, mask};
        AOCC_LAST_EA_OFS:   next_dat = last_ea;
        AOCC_LAST_INSN_OFS: next_dat = last_insn;
        default:            next_dat = 32'h0000_0000;  // Unmapped reads zero
      endcase
    end
    next_irq = |(next_status & next_mask);
  end

  // Register file flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl      <= AOCC_CTRL_RST;
      status    <= '0;
      mask      <= AOCC_MASK_RST;
      last_ea   <= 32'h0000_0000;
      last_insn <= 32'h0000_0000;
      wb_dat_o  <= 32'h0000_0000;
      wb_ack_o  <= 1'b0;
      irq_o     <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      status    <= next_status;
      mask      <= next_mask;
      last_ea   <= next_last_ea;
      last_insn <= next_last_insn;
      wb_dat_o  <= next_dat;
      wb_ack_o  <= next_ack;
      irq_o     <= next_irq;
    end
  end

endmodule : aocc_top
`default_nettype wire
